// >>> ncopa_core.sv
`timescale 1ns/10ps
// Contract
// - Each reference clock rising edge outside power-down, with converter queue space, adds the active increment to the phase accumulator.
// - The accumulator wraps modulo two to the thirty-two without saturating.
// - The increment is the 32-bit tuning word, so a larger word overflows faster.
// - Output frequency is tuning word times reference rate over two to the thirty-two.
// - The phase is cut to 14 bits and mapped to its cosine amplitude.
// - Each reference cycle that advances the accumulator queues a 10-bit cosine code for the converter.
// - A new tuning word never resets or jumps the accumulator.
// - A reference rate below 1 MHz puts the core into power-down by itself.
// - In clock-loss power-down the core resumes once the rate is above the threshold again.
// - A rising edge of the update strobe moves the loaded tuning word into the increment.
// - Master reset clears the tuning and phase registers to zero.
// - After reset the output reaches the zero-phase cosine after 13 reference cycles.

module ncopa_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("FIFO depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
  logic             push, pop;

  assign in_ready  = (wr_q - rd_q) != (AW + 1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem_q[rd_q[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // Storage needs no reset; empty flag guards it
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule : ncopa_fifo

module ncopa_core
  import ncopa_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  input  wire logic                reference_clock_input,
  input  wire logic                frequency_update_strobe,
  input  wire logic [FTW_W-1:0]    tuning_word,
  output logic                     dac_valid,
  input  wire logic                dac_ready,
  output logic      [SAMPLE_W-1:0] dac_sample,
  output logic                     power_down
);

  // Quarter sine, 17 knots, full scale 511
  function automatic logic [8:0] knot(input logic [4:0] k);
    unique case (k)
      5'h00: knot = 9'h000;
      5'h01: knot = 9'h032;
      5'h02: knot = 9'h064;
      5'h03: knot = 9'h094;
      5'h04: knot = 9'h0C4;
      5'h05: knot = 9'h0F1;
      5'h06: knot = 9'h11C;
      5'h07: knot = 9'h144;
      5'h08: knot = 9'h169;
      5'h09: knot = 9'h18B;
      5'h0A: knot = 9'h1A9;
      5'h0B: knot = 9'h1C3;
      5'h0C: knot = 9'h1D8;
      5'h0D: knot = 9'h1E9;
      5'h0E: knot = 9'h1F5;
      5'h0F: knot = 9'h1FD;
      5'h10: knot = 9'h1FF;
      default: knot = 9'h1FF;
    endcase
  endfunction : knot

  function automatic logic [SAMPLE_W-1:0] cos_code(input logic [PHASE_W-1:0] ph);
    logic [PHASE_W-1:0] s;
    logic [12:0]        idx;
    logic [8:0]         a, b, mag;
    logic [16:0]        step;
    s    = ph + QUARTER_TURN;
    // Mirror about the crest so phase zero lands on full scale
    idx  = s[12] ? 13'(13'h1000 - {1'b0, s[11:0]}) : {1'b0, s[11:0]};
    a    = knot(idx[12:8]);
    b    = knot(5'(idx[12:8] + 5'h01));
    // Linear interpolation keeps the table tiny
    step = 17'((b - a) * idx[FRAC_W-1:0]);
    mag  = a + step[16:8];
    cos_code = s[13] ? SAMPLE_W'(MID_CODE - mag) : SAMPLE_W'(MID_CODE + mag);
  endfunction : cos_code

  logic                   ref_prev_q, ref_prev_d, upd_prev_q, upd_prev_d;
  logic                   ref_rise, upd_rise, advance, fifo_ready;
  logic [FTW_W-1:0]       acc_q, acc_d, ftw_q, ftw_d;
  logic [LOSS_W-1:0]      gap_q, gap_d;
  logic                   pd_q, pd_d;
  ncopa_stage_type        pipe_q [PIPE_DEPTH];
  ncopa_stage_type        pipe_d [PIPE_DEPTH];
  logic [SAMPLE_W-1:0]    sample_q, sample_d;

  assign ref_rise   = reference_clock_input & ~ref_prev_q;
  assign upd_rise   = frequency_update_strobe & ~upd_prev_q;
  // A full converter queue costs reference ticks rather than samples
  assign advance    = ref_rise & ~pd_q & fifo_ready;
  assign power_down = pd_q;

  always_comb begin
    ref_prev_d = reference_clock_input;
    upd_prev_d = frequency_update_strobe;
    ftw_d = upd_rise ? tuning_word : ftw_q;
    acc_d = advance ? acc_q + ftw_q : acc_q;
    gap_d = ref_rise ? '0 : (gap_q < LOSS_W'(LOSS_CYC) ? gap_q + 1'b1 : gap_q);
    pd_d  = pd_q;
    if (!pd_q && gap_q == LOSS_W'(LOSS_CYC)) begin
      pd_d = 1'b1;
    end else if (pd_q && ref_rise && gap_q < LOSS_W'(LOSS_CYC)) begin
      pd_d = 1'b0;
    end
  end

  always_comb begin
    for (int i = 0; i < PIPE_DEPTH; i++) begin
      pipe_d[i] = pipe_q[i];
    end
    sample_d = sample_q;
    if (advance) begin
      pipe_d[0] = '{vld: 1'b1, ph: acc_q[FTW_W-1 -: PHASE_W]};
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        pipe_d[i] = pipe_q[i-1];
      end
      sample_d = pipe_q[PIPE_DEPTH-1].vld ? cos_code(pipe_q[PIPE_DEPTH-1].ph) : MID_CODE;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ref_prev_q <= 1'b0;
      upd_prev_q <= 1'b0;
      ftw_q      <= FTW_RST;
      acc_q      <= ACC_RST;
      gap_q      <= '0;
      pd_q       <= 1'b0;
      sample_q   <= MID_CODE;
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe_q[i] <= '0;
      end
    end else begin
      ref_prev_q <= ref_prev_d;
      upd_prev_q <= upd_prev_d;
      ftw_q      <= ftw_d;
      acc_q      <= acc_d;
      gap_q      <= gap_d;
      pd_q       <= pd_d;
      sample_q   <= sample_d;
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe_q[i] <= pipe_d[i];
      end
    end
  end

  ncopa_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .in_valid  (advance),
    .in_ready  (fifo_ready),
    .in_data   (sample_d),
    .out_valid (dac_valid),
    .out_ready (dac_ready),
    .out_data  (dac_sample)
  );

  // Helper: count of advancing ticks since reset, saturating at RST_LATENCY
  logic [3:0] adv_cnt_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      adv_cnt_q <= 4'h0;
    end else if (advance && adv_cnt_q < 4'(RST_LATENCY)) begin
      adv_cnt_q <= adv_cnt_q + 4'h1;
    end
  end

  sequence s_quiet_ref;
    !pd_q && gap_q == LOSS_W'(LOSS_CYC);
  endsequence

  sequence s_fast_edge;
    pd_q && ref_rise && gap_q < LOSS_W'(LOSS_CYC);
  endsequence

  AST_ACC_ADD: assert property (@(posedge sys_clk) disable iff (!nrst)
    advance |=> acc_q == $past(acc_q) + $past(ftw_q))
    else $error("accumulator did not add increment");

  AST_ACC_WRAP: assert property (@(posedge sys_clk) disable iff (!nrst)
    (advance && (33'(acc_q) + 33'(ftw_q)) > 33'h0_FFFF_FFFF) |=> acc_q < $past(acc_q))
    else $error("accumulator did not wrap");

  AST_FTW_LOAD: assert property (@(posedge sys_clk) disable iff (!nrst)
    upd_rise |=> ftw_q == $past(tuning_word) ##1 ftw_q == $past(ftw_q))
    else $error("tuning word not loaded on strobe");

  AST_NO_JUMP: assert property (@(posedge sys_clk) disable iff (!nrst)
    (upd_rise && !advance) |=> acc_q == $past(acc_q))
    else $error("accumulator jumped on update");

  AST_LOSS_PD: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_quiet_ref |=> pd_q)
    else $error("slow reference did not power down");

  AST_RESUME: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_fast_edge |=> !pd_q)
    else $error("core did not resume");

  AST_PD_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
    pd_q [*2] |-> $stable(acc_q) && $stable(sample_q))
    else $error("state moved during power-down");

  AST_RST_ZERO: assert property (@(posedge sys_clk) disable iff (!nrst)
    adv_cnt_q == 4'h0 |-> acc_q == ACC_RST)
    else $error("accumulator not zero after reset");

  AST_LATENCY: assert property (@(posedge sys_clk) disable iff (!nrst)
    (adv_cnt_q < 4'(RST_LATENCY) |-> sample_q == MID_CODE) and
    ($rose(adv_cnt_q == 4'(RST_LATENCY)) && ftw_q == FTW_RST |-> sample_q == COS0))
    else $error("reset latency wrong");

  AST_PHASE_TOP: assert property (@(posedge sys_clk) disable iff (!nrst)
    advance |=> pipe_q[0].ph == $past(acc_q[FTW_W-1 -: PHASE_W]) && pipe_q[0].vld)
    else $error("phase not from accumulator top");

  AST_COS_OUT: assert property (@(posedge sys_clk) disable iff (!nrst)
    (advance && pipe_q[PIPE_DEPTH-1].vld) |=>
      sample_q == cos_code($past(pipe_q[PIPE_DEPTH-1].ph)))
    else $error("sample is not the cosine of phase");
endmodule : ncopa_core

// >>> ncopa_core_tb.sv
`timescale 1ns/10ps
module ncopa_core_tb;
  import ncopa_pkg::*;
  localparam logic [FTW_W-1:0] QTR = 32'h4000_0000;
  logic                sys_clk = 1'b0;
  logic                nrst = 1'b0;
  logic                ref_clk = 1'b0;
  logic                strobe = 1'b0;
  logic                stall = 1'b0;
  logic [FTW_W-1:0]    ftw = 32'h0000_0000;
  logic                dac_valid;
  logic                dac_ready;
  logic                power_down;
  logic [SAMPLE_W-1:0] dac_sample;
  int                  mismatches = 0;
  int                  check_count = 0;
  int                  cycles = 0;

  ncopa_core #(.DEPTH(FIFO_DEPTH)) i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .reference_clock_input(ref_clk),
    .frequency_update_strobe(strobe), .tuning_word(ftw), .dac_valid(dac_valid),
    .dac_ready(dac_ready), .dac_sample(dac_sample), .power_down(power_down));

  ncopa_dac_model i_dac (
    .sys_clk(sys_clk), .dac_valid(dac_valid), .dac_sample(dac_sample),
    .stall(stall), .dac_ready(dac_ready));

  always #2 sys_clk = ~sys_clk;

  // Whole run is well under two thousand cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Lookup is interpolated, so allow three codes either way
  function automatic logic near(input logic [10:0] a, input logic [10:0] e);
    return (a + 11'h003 >= e) && (a <= e + 11'h003);
  endfunction : near

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  // Low phase of one cycle keeps ticks legal
  task automatic tick;
    ref_clk <= 1'b1;
    cyc(1);
    ref_clk <= 1'b0;
    cyc(1);
  endtask : tick

  task automatic load(input logic [FTW_W-1:0] w);
    ftw <= w;
    strobe <= 1'b1;
    cyc(1);
    strobe <= 1'b0;
    cyc(1);
  endtask : load

  task automatic do_reset;
    nrst <= 1'b0;
    cyc(20);
    check(dac_valid, 1'b0);
    check(power_down, 1'b0);
    nrst <= 1'b1;
    cyc(1);
    i_dac.got.delete();
  endtask : do_reset

  task automatic t_latency;
    repeat (13) tick();
    cyc(4);
    check(i_dac.got.size(), 13);
    for (int i = 0; i < 12; i++) begin
      check(i_dac.got[i], MID_CODE);
    end
    check(i_dac.got[12], COS0);
  endtask : t_latency

  task automatic t_period;
    int n;
    load(QTR);
    repeat (20) tick();
    cyc(4);
    n = i_dac.got.size();
    for (int i = 0; i < 4; i++) begin
      check(i_dac.got[n-4+i], i_dac.got[n-8+i]);
      check(near({1'b0, i_dac.got[n-8+i]} + {1'b0, i_dac.got[n-6+i]}, 11'h400), 1);
      check(i_dac.got[n-8+i] != i_dac.got[n-7+i], 1);
    end
  endtask : t_period

  task automatic t_pdown;
    int n;
    cyc(260);
    check(power_down, 1'b1);
    n = i_dac.got.size();
    tick();
    cyc(3);
    check(i_dac.got.size(), n);
    check(power_down, 1'b1);
    tick();
    cyc(3);
    check(power_down, 1'b0);
  endtask : t_pdown

  task automatic t_full;
    int n;
    stall <= 1'b1;
    n = i_dac.got.size();
    repeat (10) tick();
    cyc(3);
    check(dac_valid, 1'b1);
    check(i_dac.got.size(), n);
    stall <= 1'b0;
    cyc(12);
    check(i_dac.got.size() - n, FIFO_DEPTH);
    check(dac_valid, 1'b0);
  endtask : t_full

  task automatic t_cont;
    do_reset();
    load(QTR);
    tick();
    tick();
    load(32'h0000_0000);
    repeat (16) tick();
    cyc(4);
    check(i_dac.got[$] < 10'h300, 1);
    check(i_dac.got[$], i_dac.got[$-1]);
  endtask : t_cont

  initial begin
    do_reset();
    t_latency();
    t_period();
    t_pdown();
    t_full();
    t_cont();
    close_out();
  end
endmodule : ncopa_core_tb

// >>> ncopa_dac_model.sv
`timescale 1ns/10ps
// Converter side: takes a sample on each handshake, stalls on request
module ncopa_dac_model
  import ncopa_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                dac_valid,
  input  wire logic [SAMPLE_W-1:0] dac_sample,
  input  wire logic                stall,
  output logic                     dac_ready
);
  logic [SAMPLE_W-1:0] got[$];

  assign dac_ready = !stall;

  always @(posedge sys_clk) begin
    if (dac_valid && dac_ready) begin
      got.push_back(dac_sample);
    end
  end
endmodule : ncopa_dac_model

// >>> ncopa_pkg.sv
package ncopa_pkg;

  // Datapath widths
  localparam int unsigned FTW_W    = 32;
  localparam int unsigned PHASE_W  = 14;
  localparam int unsigned SAMPLE_W = 10;

  // Reset values
  localparam logic [FTW_W-1:0]    ACC_RST  = 32'h0000_0000;
  localparam logic [FTW_W-1:0]    FTW_RST  = 32'h0000_0000;
  localparam logic [SAMPLE_W-1:0] MID_CODE = 10'h200;
  localparam logic [SAMPLE_W-1:0] COS0     = 10'h3FF;

  // Reset output latency in reference cycles
  localparam int unsigned RST_LATENCY = 13;
  localparam int unsigned PIPE_DEPTH  = RST_LATENCY - 1;

  // Clock-loss threshold
  localparam int unsigned SYS_PERIOD_PS   = 4000;
  localparam int unsigned REF_MIN_FREQ_KHZ = 1000;
  localparam int unsigned REF_MAX_PERIOD_PS = 1000000000 / REF_MIN_FREQ_KHZ;
  localparam int unsigned LOSS_CYC = REF_MAX_PERIOD_PS / SYS_PERIOD_PS;
  localparam int unsigned LOSS_W   = $clog2(LOSS_CYC + 1);

  // Sine table geometry
  localparam int unsigned SEG_W    = 4;
  localparam int unsigned FRAC_W   = 8;
  localparam logic [PHASE_W-1:0] QUARTER_TURN = 14'h1000;

  localparam int unsigned FIFO_DEPTH = 8;

  typedef struct packed {
    logic               vld;
    logic [PHASE_W-1:0] ph;
  } ncopa_stage_type;

endpackage : ncopa_pkg
